// [mua_pkg.sv]
// Shared constants for the MDIO user access channel
package mua_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_ACCESS = 8'h00;
	localparam logic [7:0] ADDR_SELECT = 8'h04;
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_MASK   = 8'h10;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int GO_BIT      = 31;
	localparam int DIR_BIT     = 30;
	localparam int ACK_BIT     = 29;
	localparam int REG_MSB     = 25;
	localparam int REG_LSB     = 21;
	localparam int PHY_MSB     = 20;
	localparam int PHY_LSB     = 16;
	localparam int DATA_MSB    = 15;
	localparam int LSEL_BIT    = 7;
	localparam int LIEN_BIT    = 6;
	localparam int MON_MSB     = 4;
	localparam int ENABLE_BIT  = 0;
	localparam int EVT_DONE    = 0;
	localparam int EVT_LINK    = 1;
	localparam int NUM_EVT     = 2;
	// ************************************************************
	// Reset values and frame constants
	// ************************************************************
	localparam logic [31:0] ACCESS_RST   = 32'h0000_0000;
	localparam logic [7:0]  SELECT_RST   = 8'h00;
	localparam logic [31:0] PREAMBLE     = 32'hFFFF_FFFF;
	localparam logic [1:0]  FRAME_START  = 2'h1;
	localparam logic [1:0]  OP_WRITE     = 2'h1;
	localparam logic [1:0]  OP_READ      = 2'h2;
	localparam logic [1:0]  TA_WRITE     = 2'h2;
	localparam logic [5:0]  LAST_BIT     = 6'h3F;
	localparam logic [5:0]  TA_LAST_BIT  = 6'h2F;
	localparam logic [5:0]  TA_FIRST_BIT = 6'h2E;
	localparam logic [4:0]  STATUS_REG   = 5'h01;
	localparam int          LINK_BIT     = 2;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int MDC_PERIOD_NS = 400;
	localparam int MDC_HALF_CYC  = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);
	typedef enum logic [1:0] {MUA_IDLE, MUA_USER, MUA_POLL} mua_state_t;
endpackage

// [mua_sync.sv]
// Three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module mua_sync (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else if (ce) begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// Only the later two stages feed the decision
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b1;
		end else if (ce && s2 == s3) begin
			level <= s3;
		end
	end
endmodule

// [mua_sticky.sv]
// Sticky event bit: a set in the clearing cycle wins
`timescale 1ns/1ps
module mua_sticky (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (ce) begin
			if (set) begin
				flag <= 1'b1;
			end else if (clr) begin
				flag <= 1'b0;
			end
		end
	end
endmodule

// [mua_channel.sv]
// MDIO user access channel: registers, frame engine, link monitor, interrupt
`timescale 1ns/1ps
module mua_channel #(
	parameter int MDC_HALF = mua_pkg::MDC_HALF_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	output logic             irq,
	output logic             mdc,
	output logic             mdio_out,
	output logic             mdio_oe,
	input  wire logic        mdio_in
);
	// The synchroniser settles four cycles after an MDC edge, so a half period
	// shorter than five would sample the previous bit
	if (MDC_HALF < 5 || MDC_HALF > 255) begin
		$error("MDC_HALF must lie in 5..255");
	end
	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_a;
	logic rst_n;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end
	// ************************************************************
	// Registers
	// ************************************************************
	logic                    go;
	logic                    dir;
	logic                    ack;
	logic [4:0]              phy_reg_number;
	logic [4:0]              phy_target_addr;
	logic [15:0]             data;
	logic                    link_source_select;
	logic                    link_irq_enable;
	logic [4:0]              monitored_phy_addr;
	logic                    enable;
	logic [mua_pkg::NUM_EVT-1:0] mask;
	logic [mua_pkg::NUM_EVT-1:0] status;
	logic                    user_done;
	logic                    poll_done;
	logic                    link_evt;
	logic [15:0]             rx_shift;
	logic                    rx_ack;
	logic                    wr_access;
	logic                    wr_select;
	assign wr_access = ce && wr && addr == mua_pkg::ADDR_ACCESS;
	assign wr_select = ce && wr && addr == mua_pkg::ADDR_SELECT;
	// Go: set only by an allowed write, cleared by completion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			go <= 1'b0;
		end else if (ce) begin
			if (user_done) begin
				go <= 1'b0;
			end else if (wr_access && !go && wdata[mua_pkg::GO_BIT] && enable) begin
				go <= 1'b1;
			end
		end
	end
	// Fields freeze while an access is pending so the frame cannot tear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir             <= mua_pkg::ACCESS_RST[mua_pkg::DIR_BIT];
			ack             <= mua_pkg::ACCESS_RST[mua_pkg::ACK_BIT];
			phy_reg_number  <= mua_pkg::ACCESS_RST[mua_pkg::REG_MSB:mua_pkg::REG_LSB];
			phy_target_addr <= mua_pkg::ACCESS_RST[mua_pkg::PHY_MSB:mua_pkg::PHY_LSB];
			data            <= mua_pkg::ACCESS_RST[mua_pkg::DATA_MSB:0];
		end else if (ce) begin
			if (user_done) begin
				ack <= !dir && rx_ack;
				if (!dir) begin
					data <= rx_shift;
				end
			end else if (wr_access && !go) begin
				dir             <= wdata[mua_pkg::DIR_BIT];
				ack             <= wdata[mua_pkg::ACK_BIT];
				phy_reg_number  <= wdata[mua_pkg::REG_MSB:mua_pkg::REG_LSB];
				phy_target_addr <= wdata[mua_pkg::PHY_MSB:mua_pkg::PHY_LSB];
				data            <= wdata[mua_pkg::DATA_MSB:0];
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_source_select <= mua_pkg::SELECT_RST[mua_pkg::LSEL_BIT];
			link_irq_enable    <= mua_pkg::SELECT_RST[mua_pkg::LIEN_BIT];
			monitored_phy_addr <= mua_pkg::SELECT_RST[mua_pkg::MON_MSB:0];
		end else if (wr_select) begin
			link_source_select <= wdata[mua_pkg::LSEL_BIT];
			link_irq_enable    <= wdata[mua_pkg::LIEN_BIT];
			monitored_phy_addr <= wdata[mua_pkg::MON_MSB:0];
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable <= 1'b0;
			mask   <= '0;
		end else if (ce && wr) begin
			if (addr == mua_pkg::ADDR_CTRL) begin
				enable <= wdata[mua_pkg::ENABLE_BIT];
			end
			if (addr == mua_pkg::ADDR_MASK) begin
				mask <= wdata[mua_pkg::NUM_EVT-1:0];
			end
		end
	end
	// ************************************************************
	// Read port
	// ************************************************************
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		unique case (addr)
			mua_pkg::ADDR_ACCESS: begin
				next_rdata[mua_pkg::GO_BIT]                    = go;
				next_rdata[mua_pkg::DIR_BIT]                   = dir;
				next_rdata[mua_pkg::ACK_BIT]                   = ack;
				next_rdata[mua_pkg::REG_MSB:mua_pkg::REG_LSB]  = phy_reg_number;
				next_rdata[mua_pkg::PHY_MSB:mua_pkg::PHY_LSB]  = phy_target_addr;
				next_rdata[mua_pkg::DATA_MSB:0]                = data;
			end
			mua_pkg::ADDR_SELECT: begin
				next_rdata[mua_pkg::LSEL_BIT]   = link_source_select;
				next_rdata[mua_pkg::LIEN_BIT]   = link_irq_enable;
				next_rdata[mua_pkg::MON_MSB:0]  = monitored_phy_addr;
			end
			mua_pkg::ADDR_CTRL: next_rdata[mua_pkg::ENABLE_BIT] = enable;
			mua_pkg::ADDR_STATUS: next_rdata[mua_pkg::NUM_EVT-1:0] = status;
			mua_pkg::ADDR_MASK: next_rdata[mua_pkg::NUM_EVT-1:0] = mask;
			default: next_rdata = '0;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= rd ? next_rdata : '0;
		end
	end
	// ************************************************************
	// Interrupts
	// ************************************************************
	logic stat_clr;
	assign stat_clr = rd && addr == mua_pkg::ADDR_STATUS;
	mua_sticky u_done_evt (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.set      (user_done),
		.clr      (stat_clr),
		.flag     (status[mua_pkg::EVT_DONE])
	);
	mua_sticky u_link_evt (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.set      (link_evt),
		.clr      (stat_clr),
		.flag     (status[mua_pkg::EVT_LINK])
	);
	assign irq = |(status & mask);
	// ************************************************************
	// Frame engine
	// ************************************************************
	mua_pkg::mua_state_t state;
	logic       mdio_sync;
	logic [7:0] div;
	logic [5:0] bit_idx;
	logic [63:0] tx_shift;
	logic        half_tick;
	logic        frame_end;
	logic        frame_read;
	mua_sync u_mdio_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.pin      (mdio_in),
		.level    (mdio_sync)
	);
	assign half_tick  = state != mua_pkg::MUA_IDLE && div == 8'(MDC_HALF - 1);
	assign frame_end  = half_tick && mdc && bit_idx == mua_pkg::LAST_BIT;
	assign frame_read = state == mua_pkg::MUA_POLL || !dir;
	assign user_done  = frame_end && state == mua_pkg::MUA_USER;
	assign poll_done  = frame_end && state == mua_pkg::MUA_POLL;
	// The user request outranks link polling; polling only fills idle time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= mua_pkg::MUA_IDLE;
			tx_shift <= '0;
		end else if (ce) begin
			unique case (state)
				mua_pkg::MUA_IDLE: begin
					if (go) begin
						state    <= mua_pkg::MUA_USER;
						tx_shift <= {mua_pkg::PREAMBLE, mua_pkg::FRAME_START,
							dir ? mua_pkg::OP_WRITE : mua_pkg::OP_READ,
							phy_target_addr, phy_reg_number,
							mua_pkg::TA_WRITE, data};
					end else if (enable) begin
						state    <= mua_pkg::MUA_POLL;
						tx_shift <= {mua_pkg::PREAMBLE, mua_pkg::FRAME_START,
							mua_pkg::OP_READ, monitored_phy_addr,
							mua_pkg::STATUS_REG, mua_pkg::TA_WRITE, 16'h0000};
					end
				end
				mua_pkg::MUA_USER, mua_pkg::MUA_POLL: begin
					if (frame_end) begin
						state <= mua_pkg::MUA_IDLE;
					end else if (half_tick && mdc) begin
						tx_shift <= {tx_shift[62:0], 1'b0};
					end
				end
				default: state <= mua_pkg::MUA_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div     <= '0;
			mdc     <= 1'b0;
			bit_idx <= '0;
		end else if (ce) begin
			if (state == mua_pkg::MUA_IDLE) begin
				div     <= '0;
				mdc     <= 1'b0;
				bit_idx <= '0;
			end else if (half_tick) begin
				div <= '0;
				mdc <= !mdc;
				if (mdc) begin
					bit_idx <= bit_idx + 6'h01;
				end
			end else begin
				div <= div + 8'h01;
			end
		end
	end
	// Sample on the rising MDC half; PHY drives the second turnaround bit low to acknowledge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_shift <= '0;
			rx_ack   <= 1'b0;
		end else if (ce && half_tick && !mdc) begin
			if (bit_idx == mua_pkg::TA_LAST_BIT) begin
				rx_ack <= !mdio_sync;
			end else if (bit_idx > mua_pkg::TA_LAST_BIT) begin
				rx_shift <= {rx_shift[14:0], mdio_sync};
			end
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdio_out <= 1'b1;
			mdio_oe  <= 1'b0;
		end else if (ce) begin
			mdio_out <= tx_shift[63];
			mdio_oe  <= state != mua_pkg::MUA_IDLE &&
				!(frame_read && bit_idx >= mua_pkg::TA_FIRST_BIT);
		end
	end
	// ************************************************************
	// Link monitor
	// ************************************************************
	logic link_up;
	logic link_valid;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_up    <= 1'b0;
			link_valid <= 1'b0;
		end else if (ce) begin
			if (wr_select) begin
				link_valid <= 1'b0;
			end else if (poll_done && rx_ack) begin
				link_up    <= rx_shift[mua_pkg::LINK_BIT];
				link_valid <= 1'b1;
			end
		end
	end
	assign link_evt = poll_done && rx_ack && link_valid && link_irq_enable &&
		rx_shift[mua_pkg::LINK_BIT] != link_up;
	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !ce);
	sequence s_go_write;
		wr_access && wdata[mua_pkg::GO_BIT] && !go;
	endsequence
	a_go_needs_enable: assert property ((s_go_write and !enable) |=> !go)
		else $error("go set while engine disabled");
	a_go_zero_write: assert property (go && !user_done |=> go)
		else $error("go dropped before access end");
	a_go_self_clear: assert property (user_done |=> !go && status[mua_pkg::EVT_DONE])
		else $error("go not cleared at access end");
	a_fields_frozen: assert property (go && wr_access && !user_done
		|=> $stable(data) && $stable(phy_target_addr) && $stable(dir))
		else $error("access register changed while busy");
	a_write_drives: assert property (state == mua_pkg::MUA_USER && dir
		&& bit_idx > mua_pkg::TA_LAST_BIT |=> mdio_oe)
		else $error("write frame released the data line");
	a_ack_on_read: assert property (user_done |=> ack == (!$past(dir) && $past(rx_ack)))
		else $error("acknowledge wrong after access");
	a_read_loads: assert property (user_done && !dir |=> data == $past(rx_shift))
		else $error("read data not loaded");
	a_link_gated: assert property (!link_irq_enable && !status[mua_pkg::EVT_LINK]
		|=> !status[mua_pkg::EVT_LINK])
		else $error("link event while disabled");
	a_reserved_zero: assert property (rd && addr == mua_pkg::ADDR_SELECT
		|=> rdata[31:8] == 24'h000000 && !rdata[5])
		else $error("reserved select bits nonzero");
	a_go_starts: assert property (go && state == mua_pkg::MUA_IDLE
		|=> state == mua_pkg::MUA_USER)
		else $error("pending access not started");
endmodule

// [mua_phy_model.sv]
// Behavioural PHY on the management bus that answers one address
`timescale 1ns/1ps
module mua_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h03
) (
	input  wire logic mdc,
	input  wire logic line,
	input  wire logic link_up,
	output logic      phy_oe,
	output logic      phy_d
);
	// ************************************************************
	// State
	// ************************************************************
	logic [33:0] sh;
	logic [15:0] regs [32];
	logic [15:0] rdv;
	int          pos;
	int          fc;
	logic        rd_go;
	initial begin
		sh = '0;
		pos = 0;
		fc = 0;
		rd_go = 1'b0;
		phy_oe = 1'b0;
		phy_d = 1'b1;
		foreach (regs[i]) regs[i] = 16'h0000;
	end
	// ************************************************************
	// Frame capture on the rising clock edge
	// ************************************************************
	// A frame is only seen after a full preamble, so stray ones never start one
	always @(posedge mdc) begin
		sh = {sh[32:0], line};
		if (pos == 0) begin
			if (sh === {32'hFFFF_FFFF, 2'h1}) pos = 34;
		end else begin
			if (pos == 45 && sh[11:10] == 2'h2 && sh[9:5] == PHY_ADDR) begin
				rdv = (sh[4:0] == 5'h01) ? {13'h0000, link_up, 2'h0} : regs[sh[4:0]];
				rd_go = 1'b1;
				fc = 0;
			end
			if (pos == 63) begin
				if (sh[29:28] == 2'h1 && sh[27:23] == PHY_ADDR) regs[sh[22:18]] = sh[15:0];
				pos = 0;
			end else begin
				pos++;
			end
		end
	end
	// ************************************************************
	// Read answer, launched after the falling edge
	// ************************************************************
	// Released line is left to the pull-up rather than held at the last bit
	always @(negedge mdc) begin
		if (rd_go) begin
			fc++;
			if (fc == 2) begin
				phy_oe = 1'b1;
				phy_d = 1'b0;
			end else if (fc >= 3 && fc <= 18) begin
				phy_d = rdv[18 - fc];
			end else if (fc == 19) begin
				phy_oe = 1'b0;
				phy_d = 1'b1;
				rd_go = 1'b0;
			end
		end
	end
endmodule

// [mdio_user_access_channel_bench.sv]
// Self-checking bench for the MDIO user access channel
`timescale 1ns/1ps
module mdio_user_access_channel_bench;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        core_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        irq;
	logic        mdc;
	logic        mdio_out;
	logic        mdio_oe;
	logic        phy_oe;
	logic        phy_d;
	logic        link_up;
	logic        mdio_line;
	logic [31:0] d;
	int          num_errors;
	int          checks_done;
	// Pull-up on the shared line
	assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_d : 1'b1);
	mua_channel #(.MDC_HALF(8)) i_dut (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (1'b1),
		.addr     (addr),
		.wdata    (wdata),
		.wr       (wr),
		.rd       (rd),
		.rdata    (rdata),
		.irq      (irq),
		.mdc      (mdc),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.mdio_in  (mdio_line)
	);
	mua_phy_model #(.PHY_ADDR(5'h03)) i_phy (
		.mdc     (mdc),
		.line    (mdio_line),
		.link_up (link_up),
		.phy_oe  (phy_oe),
		.phy_d   (phy_d)
	);
	// ************************************************************
	// Clock and tasks
	// ************************************************************
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Polls go under a bound, since a background poll may delay the start
	task automatic wait_done(output logic [31:0] v);
		int n;
		n = 0;
		do begin
			rd_reg(mua_pkg::ADDR_ACCESS, v);
			n++;
		end while (v[31] !== 1'b0 && n < 1500);
		chk({31'h0, v[31]}, 32'h0000_0000);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		num_errors = 0;
		checks_done = 0;
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		link_up = 1'b0;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_reg(mua_pkg::ADDR_ACCESS, d);
		chk(d, 32'h0000_0000);
		rd_reg(mua_pkg::ADDR_SELECT, d);
		chk(d, 32'h0000_0000);
		wr_reg(mua_pkg::ADDR_ACCESS, 32'h9C43_1234);
		rd_reg(mua_pkg::ADDR_ACCESS, d);
		chk(d, 32'h0043_1234);
		wr_reg(8'h20, 32'hFFFF_FFFF);
		rd_reg(8'h20, d);
		chk(d, 32'h0000_0000);
		wr_reg(mua_pkg::ADDR_CTRL, 32'h0000_0001);
		wr_reg(mua_pkg::ADDR_MASK, 32'h0000_0003);
		// Write access to PHY 3 register 5, then a blocked overwrite
		wr_reg(mua_pkg::ADDR_ACCESS, 32'hC0A3_BEEF);
		rd_reg(mua_pkg::ADDR_ACCESS, d);
		chk(d, 32'hC0A3_BEEF);
		wr_reg(mua_pkg::ADDR_ACCESS, 32'h4000_1111);
		rd_reg(mua_pkg::ADDR_ACCESS, d);
		chk(d, 32'hC0A3_BEEF);
		wait_done(d);
		chk({16'h0000, i_phy.regs[5]}, 32'h0000_BEEF);
		chk({31'h0, irq}, 32'h0000_0001);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_0001, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		// Zero in go starts nothing
		wr_reg(mua_pkg::ADDR_ACCESS, 32'h40A3_0000);
		repeat (1500) @(posedge core_clk);
		rd_reg(mua_pkg::ADDR_ACCESS, d);
		chk(d, 32'h40A3_0000);
		// Read back from the PHY, then from an absent PHY
		wr_reg(mua_pkg::ADDR_ACCESS, 32'h80A3_0000);
		wait_done(d);
		chk(d, 32'h20A3_BEEF);
		wr_reg(mua_pkg::ADDR_ACCESS, 32'h80A7_0000);
		wait_done(d);
		chk(d & 32'hE000_0000, 32'h0000_0000);
		// Link change with monitoring of PHY 3; link source kept at zero
		wr_reg(mua_pkg::ADDR_SELECT, 32'hFFFF_FF63);
		rd_reg(mua_pkg::ADDR_SELECT, d);
		chk(d, 32'h0000_0043);
		repeat (2000) @(posedge core_clk);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		link_up = 1'b1;
		repeat (2000) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		// Masked link event keeps the line low
		wr_reg(mua_pkg::ADDR_MASK, 32'h0000_0001);
		link_up = 1'b0;
		repeat (2000) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		// Link interrupts disabled
		wr_reg(mua_pkg::ADDR_SELECT, 32'h0000_0003);
		wr_reg(mua_pkg::ADDR_MASK, 32'h0000_0003);
		repeat (2000) @(posedge core_clk);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		link_up = 1'b1;
		repeat (2000) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_reg(mua_pkg::ADDR_STATUS, d);
		chk(d & 32'h0000_0002, 32'h0000_0000);
		finish_test();
	end
endmodule
